// [logic/core_special_state_defines.svh]
// Purpose: Bit positions, reset values and widths of the core special state registers
// Assumes: Included by the package and by the register-file module
// Notes: Definitions only
`ifndef CORE_SPECIAL_STATE_DEFINES_SVH
`define CORE_SPECIAL_STATE_DEFINES_SVH

`define CSS_DATA_W 32
`define CSS_SPLIT_W 8
`define CSS_IDX_W 4
`define CSS_PRI_W 8
`define CSS_EXEC_T_BIT 24
`define CSS_EXEC_HI_LSB 25
`define CSS_EXEC_LO_LSB 10
`define CSS_CTRL_FLOAT_CONTEXT_ACTIVE_BIT 2
`define CSS_CTRL_STACK_SELECT_BIT 1
`define CSS_CTRL_THREAD_UNPRIVILEGED_FLAG_BIT 0
`define CSS_MASK_BIT 0
`define CSS_RST_T_BIT 1'h1
`define CSS_RST_SPLIT 8'h00
`define CSS_RST_MASK 1'h0
`define CSS_RST_BASE_PRIORITY_REG 8'h00
`define CSS_RST_CTRL_BIT 1'h0
`define CSS_PRI_BITS_DEFAULT 4

`endif

// [logic/core_special_state_pkg.sv]
// Purpose: Types shared by the core special state register file
// Assumes: Widths come from core_special_state_defines.svh
// Notes: Register selects match the special-register move encoding of the core
`include "core_special_state_defines.svh"

package core_special_state_pkg;

  typedef enum logic [2:0] {
    SEL_EXEC = 3'h0,
    SEL_PRIORITIZABLE_MASK = 3'h1,
    SEL_FAULT_MASK_A = 3'h2,
    SEL_BASE_PRIORITY_REG = 3'h3,
    SEL_CONTROL = 3'h4
  } reg_sel_e;

  // Special-register move and mask-change requests from the execute stage
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    reg_sel_e sel;
    logic [`CSS_DATA_W-1:0] wdata;
  } sr_access_s;

  typedef struct packed {
    logic en;
    logic set_mask;
    logic prioritizable_mask;
    logic fault_mask_a;
  } mask_change_s;

  // Exception entry and return events
  typedef struct packed {
    logic entry;
    logic entry_vec0;
    logic ret;
    logic ret_from_nmi;
    logic ret_psp;
    logic ret_fp;
    logic ret_t;
    logic [`CSS_SPLIT_W-1:0] ret_split;
  } exc_evt_s;

  // Instruction-flow events that touch the execution state
  typedef struct packed {
    logic exec_valid;
    logic bx_en;
    logic bx_target0;
    logic it_start;
    logic [`CSS_SPLIT_W-1:0] it_value;
    logic it_advance;
    logic mt_suspend;
    logic [`CSS_IDX_W-1:0] mt_next_idx;
    logic mt_resume;
    logic fp_used;
  } flow_evt_s;

  // Question from the exception controller: may this exception activate?
  typedef struct packed {
    logic req;
    logic [`CSS_PRI_W-1:0] pri;
    logic nmi;
    logic configurable;
  } prio_query_s;

  typedef struct packed {
    logic t_bit;
    logic [`CSS_SPLIT_W-1:0] split;
    logic prioritizable_mask;
    logic fault_mask_a;
    logic [`CSS_PRI_W-1:0] base_priority_reg;
    logic float_context_active;
    logic stack_select;
    logic thread_unprivileged_flag;
    logic use_psp;
    logic [`CSS_DATA_W-1:0] rd_data;
    logic rd_valid;
    logic allowed;
    logic allowed_valid;
    logic exec_fault;
    logic resume_valid;
    logic [`CSS_IDX_W-1:0] resume_idx;
    logic rst_vec_pending;
    logic little_endian;
  } state_s;

endpackage : core_special_state_pkg

// [logic/core_special_state_registers.sv]
// Purpose: Execution state, exception mask and control registers of the core
// Assumes: All inputs synchronous to i_ref_clk; one request of each group per cycle
// Notes: Reads answer one cycle after the request; events act on the next edge
`include "core_special_state_defines.svh"

module core_special_state_registers #(
  parameter int PRI_BITS = `CSS_PRI_BITS_DEFAULT
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Core mode and reset vector fetch
  input wire logic i_handler_mode,
  input wire logic i_rst_vec_valid,
  input wire logic i_rst_vec0,
  // Requests and events
  input wire core_special_state_pkg::sr_access_s i_access,
  input wire core_special_state_pkg::mask_change_s i_mask_change,
  input wire core_special_state_pkg::exc_evt_s i_exc,
  input wire core_special_state_pkg::flow_evt_s i_flow,
  input wire core_special_state_pkg::prio_query_s i_query,
  // Read answer
  output logic [`CSS_DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // Register state
  output logic [`CSS_DATA_W-1:0] o_exec_state,
  output logic o_prioritizable_mask,
  output logic o_fault_mask_a,
  output logic [`CSS_PRI_W-1:0] o_base_priority_threshold,
  output logic o_float_context_active,
  output logic o_stack_select,
  output logic o_thread_unprivileged_flag,
  // Derived controls
  output logic o_use_process_stack,
  output logic o_exc_allowed,
  output logic o_exc_allowed_valid,
  output logic o_exec_fault,
  output logic o_resume_valid,
  output logic [`CSS_IDX_W-1:0] o_resume_idx,
  output logic o_little_endian
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [`CSS_DATA_W-1:0] exec_word(
    input logic t_bit,
    input logic [`CSS_SPLIT_W-1:0] split
  );
    logic [`CSS_DATA_W-1:0] w;
    w = '0;
    w[`CSS_EXEC_T_BIT] = t_bit;
    w[`CSS_EXEC_HI_LSB +: 2] = split[1:0];
    w[`CSS_EXEC_LO_LSB +: 6] = split[7:2];
    return w;
  endfunction : exec_word

  function automatic logic [`CSS_PRI_W-1:0] pri_keep(input logic [`CSS_PRI_W-1:0] v);
    logic [`CSS_PRI_W-1:0] m;
    m = 8'hff << (`CSS_PRI_W - PRI_BITS);
    return v & m;
  endfunction : pri_keep

  ////////////////////////////////////////////////////////////////////////////////
  // State

  core_special_state_pkg::state_s s_q;
  core_special_state_pkg::state_s s_d;
  logic unpriv;
  logic resumable;
  logic blocked;
  logic [`CSS_PRI_W-1:0] qpri;

  always_comb begin
    s_d = s_q;
    // Unprivileged thread code cannot touch the privileged registers
    unpriv = !i_handler_mode && s_q.thread_unprivileged_flag;
    // A split value with an empty mask nibble and a nonzero upper nibble is multi-transfer state
    resumable = (s_q.split[3:0] == 4'h0) && (s_q.split[7:4] != 4'h0);
    qpri = pri_keep(i_query.pri);
    s_d.rd_valid = i_access.rd_en;
    s_d.rd_data = '0;
    s_d.exec_fault = 1'b0;
    s_d.resume_valid = 1'b0;
    s_d.little_endian = 1'b1;

    // Reads
    if (i_access.rd_en) begin
      unique case (i_access.sel)
        core_special_state_pkg::SEL_EXEC: begin
          s_d.rd_data = '0;
        end
        core_special_state_pkg::SEL_PRIORITIZABLE_MASK: begin
          s_d.rd_data[`CSS_MASK_BIT] = s_q.prioritizable_mask && !unpriv;
        end
        core_special_state_pkg::SEL_FAULT_MASK_A: begin
          s_d.rd_data[`CSS_MASK_BIT] = s_q.fault_mask_a && !unpriv;
        end
        core_special_state_pkg::SEL_BASE_PRIORITY_REG: begin
          s_d.rd_data[`CSS_PRI_W-1:0] = unpriv ? 8'h00 : s_q.base_priority_reg;
        end
        core_special_state_pkg::SEL_CONTROL: begin
          s_d.rd_data[`CSS_CTRL_FLOAT_CONTEXT_ACTIVE_BIT] = s_q.float_context_active;
          s_d.rd_data[`CSS_CTRL_STACK_SELECT_BIT] = s_q.stack_select && !i_handler_mode;
          s_d.rd_data[`CSS_CTRL_THREAD_UNPRIVILEGED_FLAG_BIT] = s_q.thread_unprivileged_flag;
        end
        default: begin
          s_d.rd_data = '0;
        end
      endcase
    end

    // Software writes; the execution state has no write path at all
    if (i_access.wr_en && !unpriv) begin
      unique case (i_access.sel)
        core_special_state_pkg::SEL_PRIORITIZABLE_MASK: begin
          s_d.prioritizable_mask = i_access.wdata[`CSS_MASK_BIT];
        end
        core_special_state_pkg::SEL_FAULT_MASK_A: begin
          s_d.fault_mask_a = i_access.wdata[`CSS_MASK_BIT];
        end
        core_special_state_pkg::SEL_BASE_PRIORITY_REG: begin
          s_d.base_priority_reg = pri_keep(i_access.wdata[`CSS_PRI_W-1:0]);
        end
        core_special_state_pkg::SEL_CONTROL: begin
          s_d.thread_unprivileged_flag = i_access.wdata[`CSS_CTRL_THREAD_UNPRIVILEGED_FLAG_BIT];
          s_d.float_context_active = i_access.wdata[`CSS_CTRL_FLOAT_CONTEXT_ACTIVE_BIT];
          if (!i_handler_mode) begin
            s_d.stack_select = i_access.wdata[`CSS_CTRL_STACK_SELECT_BIT];
          end
        end
        default: begin
          s_d.base_priority_reg = s_q.base_priority_reg;
        end
      endcase
    end
    if (i_mask_change.en && !unpriv) begin
      if (i_mask_change.prioritizable_mask) begin
        s_d.prioritizable_mask = i_mask_change.set_mask;
      end
      if (i_mask_change.fault_mask_a) begin
        s_d.fault_mask_a = i_mask_change.set_mask;
      end
    end

    // Instruction flow
    if (i_flow.fp_used) begin
      s_d.float_context_active = 1'b1;
    end
    if (i_flow.bx_en) begin
      s_d.t_bit = i_flow.bx_target0;
    end
    if (i_flow.it_start && (i_flow.it_value[3:0] != 4'h0)) begin
      s_d.split = i_flow.it_value;
    end else if (i_flow.it_advance && !resumable) begin
      // The mask shifts out one slot per instruction, four at most
      s_d.split = (s_q.split[2:0] == 3'h0) ? 8'h00 : {s_q.split[7:5], s_q.split[3:0], 1'b0};
    end
    if (i_flow.mt_suspend) begin
      s_d.split = {i_flow.mt_next_idx, 4'h0};
    end
    if (i_flow.mt_resume && resumable) begin
      s_d.resume_valid = 1'b1;
      s_d.resume_idx = s_q.split[7:4];
      s_d.split = `CSS_RST_SPLIT;
    end
    if (i_flow.exec_valid && !s_q.t_bit) begin
      s_d.exec_fault = 1'b1;
    end

    // Exception entry and return override software in the same cycle
    if (i_exc.entry) begin
      s_d.t_bit = i_exc.entry_vec0;
      s_d.split = `CSS_RST_SPLIT;
      s_d.float_context_active = 1'b0;
    end
    if (i_exc.ret) begin
      s_d.t_bit = i_exc.ret_t;
      s_d.split = i_exc.ret_split;
      s_d.stack_select = i_exc.ret_psp;
      s_d.float_context_active = i_exc.ret_fp;
      if (!i_exc.ret_from_nmi) begin
        s_d.fault_mask_a = 1'b0;
      end
    end
    if (s_q.rst_vec_pending && i_rst_vec_valid) begin
      s_d.t_bit = i_rst_vec0;
      s_d.rst_vec_pending = 1'b0;
    end

    // Handler mode always runs on the main stack
    s_d.use_psp = s_d.stack_select && !i_handler_mode;

    // Activation check
    blocked = 1'b0;
    if (!i_query.nmi) begin
      if (s_q.fault_mask_a) begin
        blocked = 1'b1;
      end
      if (i_query.configurable && s_q.prioritizable_mask) begin
        blocked = 1'b1;
      end
      if (i_query.configurable && (s_q.base_priority_reg != 8'h00) && (qpri >= s_q.base_priority_reg)) begin
        blocked = 1'b1;
      end
    end
    s_d.allowed_valid = i_query.req;
    s_d.allowed = i_query.req && !blocked;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.t_bit <= `CSS_RST_T_BIT;
      s_q.split <= `CSS_RST_SPLIT;
      s_q.prioritizable_mask <= `CSS_RST_MASK;
      s_q.fault_mask_a <= `CSS_RST_MASK;
      s_q.base_priority_reg <= `CSS_RST_BASE_PRIORITY_REG;
      s_q.stack_select <= `CSS_RST_CTRL_BIT;
      s_q.thread_unprivileged_flag <= `CSS_RST_CTRL_BIT;
      s_q.float_context_active <= `CSS_RST_CTRL_BIT;
      s_q.rst_vec_pending <= 1'b1;
      s_q.little_endian <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rd_data = s_q.rd_data;
  assign o_rd_valid = s_q.rd_valid;
  assign o_exec_state = exec_word(s_q.t_bit, s_q.split);
  assign o_prioritizable_mask = s_q.prioritizable_mask;
  assign o_fault_mask_a = s_q.fault_mask_a;
  assign o_base_priority_threshold = s_q.base_priority_reg;
  assign o_float_context_active = s_q.float_context_active;
  assign o_stack_select = s_q.stack_select;
  assign o_thread_unprivileged_flag = s_q.thread_unprivileged_flag;
  assign o_use_process_stack = s_q.use_psp;
  assign o_exc_allowed = s_q.allowed;
  assign o_exc_allowed_valid = s_q.allowed_valid;
  assign o_exec_fault = s_q.exec_fault;
  assign o_resume_valid = s_q.resume_valid;
  assign o_resume_idx = s_q.resume_idx;
  assign o_little_endian = s_q.little_endian;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  exec_read_zero_a: assert property (
    i_access.rd_en && i_access.sel == core_special_state_pkg::SEL_EXEC
    |=> o_rd_valid && o_rd_data == 32'h0000_0000)
    else $error("execution state read returned nonzero");

  exec_write_drop_a: assert property (
    i_access.wr_en && i_access.sel == core_special_state_pkg::SEL_EXEC && !i_exc.entry
    && !i_exc.ret && !i_flow.bx_en && !i_flow.it_start && !i_flow.it_advance
    && !i_flow.mt_suspend && !i_flow.mt_resume && !(s_q.rst_vec_pending && i_rst_vec_valid)
    |=> $stable(o_exec_state))
    else $error("execution state changed by a software write");

  suspend_index_a: assert property (
    i_flow.mt_suspend && !i_exc.entry && !i_exc.ret
    |=> o_exec_state[15:12] == $past(i_flow.mt_next_idx)
    && o_exec_state[26:25] == 2'h0 && o_exec_state[11:10] == 2'h0)
    else $error("suspended transfer index not recorded");

  resume_index_a: assert property (
    i_flow.mt_resume && o_exec_state[11:10] == 2'h0 && o_exec_state[26:25] == 2'h0
    && o_exec_state[15:12] != 4'h0
    |=> o_resume_valid && o_resume_idx == $past(o_exec_state[15:12]))
    else $error("resume index wrong");

  t_zero_fault_a: assert property (
    i_flow.exec_valid && !o_exec_state[24] |=> o_exec_fault)
    else $error("no fault on execution with state bit zero");

  prioritizable_mask_block_a: assert property (
    i_query.req && i_query.configurable && !i_query.nmi && o_prioritizable_mask
    |=> o_exc_allowed_valid && !o_exc_allowed)
    else $error("prioritizable mask did not block");

  fault_mask_a_block_a: assert property (
    i_query.req && o_fault_mask_a |=> o_exc_allowed == $past(i_query.nmi))
    else $error("fault mask gating wrong");

  fault_mask_a_exit_a: assert property (
    i_exc.ret && !i_exc.ret_from_nmi |=> !o_fault_mask_a)
    else $error("fault mask not cleared on handler exit");

  threshold_block_a: assert property (
    i_query.req && i_query.configurable && !i_query.nmi && !o_fault_mask_a
    && !o_prioritizable_mask && o_base_priority_threshold == 8'h00 |=> o_exc_allowed)
    else $error("zero threshold blocked an exception");

  handler_stack_a: assert property (
    i_handler_mode |=> !o_use_process_stack)
    else $error("handler mode on process stack");

  endian_a: assert property (o_little_endian)
    else $error("data endianness not little");

  // Reserved execution state bits must never show, whatever the split field holds
  exec_layout_a: assert property (
    o_exec_state[31:27] == 5'h00 && o_exec_state[23:16] == 8'h00
    && o_exec_state[9:0] == 10'h000)
    else $error("reserved execution state bits nonzero");

  mask_write_a: assert property (
    i_access.wr_en && i_access.sel == core_special_state_pkg::SEL_PRIORITIZABLE_MASK && !unpriv
    && !i_mask_change.en |=> o_prioritizable_mask == $past(i_access.wdata[0]))
    else $error("prioritizable mask write not applied");

  mask_change_a: assert property (
    i_mask_change.en && i_mask_change.fault_mask_a && !unpriv && !i_exc.ret
    |=> o_fault_mask_a == $past(i_mask_change.set_mask))
    else $error("fault mask change instruction not applied");

  threshold_low_a: assert property (
    pri_keep(o_base_priority_threshold) == o_base_priority_threshold)
    else $error("unimplemented threshold bits nonzero");

  control_read_a: assert property (
    i_access.rd_en && i_access.sel == core_special_state_pkg::SEL_CONTROL && i_handler_mode
    |=> !o_rd_data[1])
    else $error("stack select read nonzero in handler mode");

  privilege_write_a: assert property (
    i_access.wr_en && i_access.sel == core_special_state_pkg::SEL_CONTROL && !unpriv
    |=> o_thread_unprivileged_flag == $past(i_access.wdata[0]))
    else $error("thread privilege bit write not applied");

  entry_float_a: assert property (
    i_exc.entry && !i_exc.ret |=> !o_float_context_active)
    else $error("float context not cleared on exception entry");

  return_stack_a: assert property (
    i_exc.ret |=> o_stack_select == $past(i_exc.ret_psp))
    else $error("stack select not restored on exception return");

  reset_vector_a: assert property (
    s_q.rst_vec_pending && i_rst_vec_valid |=> o_exec_state[24] == $past(i_rst_vec0))
    else $error("reset vector bit not loaded into state bit");

  suspend_c: cover property (i_flow.mt_suspend ##[1:20] o_resume_valid);
  mask_block_c: cover property (o_exc_allowed_valid && !o_exc_allowed);
  stack_switch_c: cover property ($rose(o_use_process_stack));
  if_advance_c: cover property (i_flow.it_advance && s_q.split[3:0] != 4'h0);

endmodule : core_special_state_registers

// [test/testbench.sv]
// Purpose: Self-checking bench for the core special state register file
// Assumes: Inputs driven at the falling edge; pulses last one cycle
// Notes: Waits are bounded; a wait that runs out ends the run as a failure
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PRI_BITS = 4;

  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  logic handler_mode = 1'h0;
  logic vec_valid = 1'h0;
  logic vec0 = 1'h0;
  core_special_state_pkg::sr_access_s access = '0;
  core_special_state_pkg::mask_change_s mask_chg = '0;
  core_special_state_pkg::exc_evt_s exc = '0;
  core_special_state_pkg::flow_evt_s flow = '0;
  core_special_state_pkg::prio_query_s query = '0;
  logic [31:0] rd_data;
  logic rd_valid;
  logic [31:0] exec_state;
  logic pmask;
  logic fmask;
  logic [7:0] bpri;
  logic float_context_active;
  logic stack_select;
  logic thread_unprivileged_flag;
  logic use_psp;
  logic allowed;
  logic allowed_valid;
  logic exec_fault;
  logic resume_valid;
  logic [3:0] resume_idx;
  logic little_endian;
  int fails = 0;
  int n_compared = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  core_special_state_registers #(.PRI_BITS(PRI_BITS)) i_core_special_state_registers (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_handler_mode(handler_mode),
    .i_rst_vec_valid(vec_valid), .i_rst_vec0(vec0), .i_access(access),
    .i_mask_change(mask_chg), .i_exc(exc), .i_flow(flow), .i_query(query),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_exec_state(exec_state),
    .o_prioritizable_mask(pmask), .o_fault_mask_a(fmask),
    .o_base_priority_threshold(bpri), .o_float_context_active(float_context_active),
    .o_stack_select(stack_select), .o_thread_unprivileged_flag(thread_unprivileged_flag),
    .o_use_process_stack(use_psp), .o_exc_allowed(allowed),
    .o_exc_allowed_valid(allowed_valid), .o_exec_fault(exec_fault),
    .o_resume_valid(resume_valid), .o_resume_idx(resume_idx),
    .o_little_endian(little_endian)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic step();
    @(negedge i_ref_clk);
  endtask : step

  task automatic clear_events();
    access = '0;
    mask_chg = '0;
    exc = '0;
    flow = '0;
    query = '0;
    vec_valid = 1'h0;
  endtask : clear_events

  // Let the request edge pass, drop the pulse, then let the result settle
  task automatic fire();
    step();
    clear_events();
    step();
  endtask : fire

  // Pulses show one cycle after the request; poll up to four edges before failing
  task automatic wait_hi(input int which);
    logic seen;
    seen = 1'h0;
    for (int n = 0; n < 4 && !seen; n++) begin
      step();
      clear_events();
      case (which)
        0: seen = (rd_valid === 1'h1);
        1: seen = (allowed_valid === 1'h1);
        2: seen = (resume_valid === 1'h1);
        default: seen = (exec_fault === 1'h1);
      endcase
    end
    if (!seen) begin
      fails++;
      $display("unexpected pulse %0d expected 1 seen 0", which);
      complete_run();
    end
  endtask : wait_hi

  task automatic sr_write(input core_special_state_pkg::reg_sel_e sel, input logic [31:0] d);
    access.wr_en = 1'h1;
    access.sel = sel;
    access.wdata = d;
    fire();
  endtask : sr_write

  task automatic sr_read(input core_special_state_pkg::reg_sel_e sel, input logic [31:0] exp);
    access.rd_en = 1'h1;
    access.sel = sel;
    wait_hi(0);
    chk("read data", exp, rd_data);
  endtask : sr_read

  task automatic ask(input logic [7:0] pri, input logic nmi, input logic conf, input logic exp);
    query.req = 1'h1;
    query.pri = pri;
    query.nmi = nmi;
    query.configurable = conf;
    wait_hi(1);
    chk("allowed", {31'h0, exp}, {31'h0, allowed});
  endtask : ask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    fails++;
    $display("unexpected run length expected end seen hang");
    complete_run();
  end

  initial begin
    repeat (20) @(posedge i_ref_clk);
    step();
    i_rst = 1'h0;
    chk("exec state", 32'h01000000, exec_state);
    chk("stack select", 32'h0, {31'h0, stack_select});
    chk("endian", 32'h1, {31'h0, little_endian});
    vec_valid = 1'h1;
    vec0 = 1'h1;
    fire();
    chk("exec state", 32'h01000000, exec_state);
    sr_read(core_special_state_pkg::SEL_EXEC, 32'h0);
    sr_write(core_special_state_pkg::SEL_EXEC, 32'hffffffff);
    chk("exec state", 32'h01000000, exec_state);
    ask(8'hff, 1'h0, 1'h1, 1'h1);
    sr_write(core_special_state_pkg::SEL_PRIORITIZABLE_MASK, 32'hffffffff);
    sr_read(core_special_state_pkg::SEL_PRIORITIZABLE_MASK, 32'h1);
    ask(8'h00, 1'h0, 1'h1, 1'h0);
    ask(8'h00, 1'h0, 1'h0, 1'h1);
    mask_chg = '{en: 1'h1, set_mask: 1'h0, prioritizable_mask: 1'h1, fault_mask_a: 1'h0};
    fire();
    chk("prioritizable_mask", 32'h0, {31'h0, pmask});
    sr_write(core_special_state_pkg::SEL_BASE_PRIORITY_REG, 32'hffffffff);
    sr_read(core_special_state_pkg::SEL_BASE_PRIORITY_REG, {24'h0, 8'hff << (8 - PRI_BITS)});
    sr_write(core_special_state_pkg::SEL_BASE_PRIORITY_REG, 32'h80);
    chk("threshold", 32'h80, {24'h0, bpri});
    ask(8'h80, 1'h0, 1'h1, 1'h0);
    ask(8'h8f, 1'h0, 1'h1, 1'h0);
    ask(8'h70, 1'h0, 1'h1, 1'h1);
    sr_write(core_special_state_pkg::SEL_BASE_PRIORITY_REG, 32'h0);
    mask_chg = '{en: 1'h1, set_mask: 1'h1, prioritizable_mask: 1'h0, fault_mask_a: 1'h1};
    fire();
    sr_read(core_special_state_pkg::SEL_FAULT_MASK_A, 32'h1);
    ask(8'h00, 1'h1, 1'h0, 1'h1);
    ask(8'h00, 1'h0, 1'h0, 1'h0);
    exc = '{ret: 1'h1, ret_from_nmi: 1'h1, ret_t: 1'h1, default: '0};
    fire();
    chk("fault_mask_a", 32'h1, {31'h0, fmask});
    exc = '{ret: 1'h1, ret_t: 1'h1, default: '0};
    fire();
    chk("fault_mask_a", 32'h0, {31'h0, fmask});
    sr_write(core_special_state_pkg::SEL_CONTROL, 32'hfffffffe);
    sr_read(core_special_state_pkg::SEL_CONTROL, 32'h6);
    chk("process stack", 32'h1, {31'h0, use_psp});
    handler_mode = 1'h1;
    fire();
    chk("process stack", 32'h0, {31'h0, use_psp});
    sr_read(core_special_state_pkg::SEL_CONTROL, 32'h4);
    sr_write(core_special_state_pkg::SEL_CONTROL, 32'h4);
    chk("stack select", 32'h1, {31'h0, stack_select});
    chk("float context", 32'h1, {31'h0, float_context_active});
    exc = '{entry: 1'h1, entry_vec0: 1'h1, default: '0};
    fire();
    chk("float context", 32'h0, {31'h0, float_context_active});
    exc = '{ret: 1'h1, ret_t: 1'h1, default: '0};
    handler_mode = 1'h0;
    fire();
    chk("stack select", 32'h0, {31'h0, stack_select});
    flow.fp_used = 1'h1;
    fire();
    chk("float context", 32'h1, {31'h0, float_context_active});
    flow.mt_suspend = 1'h1;
    flow.mt_next_idx = 4'h5;
    fire();
    chk("exec state", 32'h01005000, exec_state);
    flow.mt_resume = 1'h1;
    wait_hi(2);
    chk("resume index", 32'h5, {28'h0, resume_idx});
    flow.it_start = 1'h1;
    flow.it_value = 8'h40;
    fire();
    chk("exec state", 32'h01000000, exec_state);
    flow.it_start = 1'h1;
    flow.it_value = 8'h47;
    fire();
    chk("exec state", 32'h07004400, exec_state);
    flow.it_advance = 1'h1;
    fire();
    chk("exec state", 32'h05004c00, exec_state);
    flow.bx_en = 1'h1;
    flow.bx_target0 = 1'h0;
    fire();
    chk("exec state", 32'h04004c00, exec_state);
    flow.exec_valid = 1'h1;
    wait_hi(3);
    flow.bx_en = 1'h1;
    flow.bx_target0 = 1'h1;
    fire();
    sr_write(core_special_state_pkg::SEL_CONTROL, 32'h1);
    chk("unprivileged", 32'h1, {31'h0, thread_unprivileged_flag});
    sr_write(core_special_state_pkg::SEL_PRIORITIZABLE_MASK, 32'h1);
    chk("prioritizable_mask", 32'h0, {31'h0, pmask});
    i_rst = 1'h1;
    repeat (3) step();
    i_rst = 1'h0;
    chk("unprivileged", 32'h0, {31'h0, thread_unprivileged_flag});
    vec_valid = 1'h1;
    vec0 = 1'h0;
    fire();
    chk("exec state", 32'h0, exec_state);
    complete_run();
  end

endmodule : testbench
